// ==== disk_drive_model.sv ====
// Behavioural model of the selected drive's read clock and serial read data.
`timescale 1ns/1ps
module disk_drive_model (
    input  wire logic       read_gate,
    input  wire logic [5:0] sync_bits,
    output logic            read_clock,
    output logic            read_bit
);
    int n;

    initial begin
        read_clock = 1'b0;
        read_bit   = 1'b1;
        forever begin
            wait (read_gate === 1'b1);
            // Edges land just off the bench clock's rising edge, so sampling never races them.
            #1;
            n = 0;
            while (read_gate === 1'b1) begin
                if (n < 300) begin
                    read_bit = 1'b0;
                end else if (n < 306) begin
                    read_bit = sync_bits[305 - n];
                end else begin
                    read_bit = n[0];
                end
                #80 read_clock = 1'b1;
                #80 read_clock = 1'b0;
                n++;
            end
            // The clock stands still off frame and the data line is not held.
            read_bit = ~read_bit;
        end
    end
endmodule

// ==== pattern_file.sv ====
// Small register file holding the search patterns, registered read data.
`timescale 1ns/1ps
module pattern_file #(
    parameter int DEPTH = 16
) (
    input  wire logic   clk,
    input  wire logic   rst_n,
    rf_port_if.mem      port
);
    logic [search_pkg::RF_DATA_W-1:0] mem_q [DEPTH];
    logic [search_pkg::RF_DATA_W-1:0] rd_q;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (port.wr_en) begin
            mem_q[port.wr_addr] <= port.wr_data;
        end
    end

    // The address is held for a whole search, so one cycle of read latency costs nothing.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_q <= '0;
        end else begin
            rd_q <= mem_q[port.rd_addr];
        end
    end

    assign port.rd_data = rd_q;
endmodule

// ==== read_sync_search.sv ====
// Bit and byte synchronisation by address pattern search on disk read data.
`timescale 1ns/1ps
module read_sync_search #(
    parameter int RF_DEPTH = 16
) (
    input  wire logic                                CLK,
    input  wire logic                                RST_N,
    input  wire logic                                DIRECTOR_EXECUTE_STROBE,
    input  wire logic                                DIRECTOR_IS_SEARCH,
    input  wire logic [search_pkg::DIR_W-1:0]        DIRECTOR_WORD,
    input  wire logic                                RF_WR_EN,
    input  wire logic [search_pkg::RF_ADDR_W-1:0]    RF_WR_ADDR,
    input  wire logic [search_pkg::RF_DATA_W-1:0]    RF_WR_DATA,
    input  wire logic                                CONTROL_SELECT_EN,
    input  wire logic                                ABORT_CLEAR,
    input  wire logic                                SECTOR_MARK,
    input  wire logic                                DRIVE_READ_CLOCK,
    input  wire logic                                DRIVE_READ_BIT,
    output logic                                     READ_GATE,
    output logic                                     READ_IN_PROGRESS,
    output logic                                     SECTOR_CHECK_EN,
    output logic                                     READ_DATA_GATE,
    output logic                                     CHECKWORD_READ_EN,
    output logic                                     CHECKWORD_PRECOND,
    output logic                                     SEARCH_ACTIVE,
    output logic                                     SYNC_SEARCH,
    output logic                                     EXECUTE_HOLD,
    output logic                                     DATA_DONE,
    output logic                                     SEARCH_ABORT,
    output logic                                     COMPOSITE_STATUS,
    output logic                                     FAULT,
    output logic                                     PATTERN_MATCH,
    output logic [7:0]                               SHIFT_DATA,
    output logic [2:0]                               BIT_COUNT
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rclk_sync_q;
    logic [1:0] rbit_sync_q;
    logic [1:0] mark_sync_q;
    logic       rclk_last_q;
    logic       mark_last_q;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rclk_sync_q <= 2'h0;
            rbit_sync_q <= 2'h0;
            mark_sync_q <= 2'h0;
            rclk_last_q <= 1'b0;
            mark_last_q <= 1'b0;
        end else begin
            rclk_sync_q <= {rclk_sync_q[0], DRIVE_READ_CLOCK};
            rbit_sync_q <= {rbit_sync_q[0], DRIVE_READ_BIT};
            mark_sync_q <= {mark_sync_q[0], SECTOR_MARK};
            rclk_last_q <= rclk_sync_q[1];
            mark_last_q <= mark_sync_q[1];
        end
    end

    logic mark_pulse;
    assign mark_pulse = mark_sync_q[1] && !mark_last_q;

    // ------------------------------------------------------------
    // Director decode
    // ------------------------------------------------------------
    logic search_strobe;
    logic other_strobe;
    assign search_strobe = DIRECTOR_EXECUTE_STROBE && DIRECTOR_IS_SEARCH;
    assign other_strobe  = DIRECTOR_EXECUTE_STROBE && !DIRECTOR_IS_SEARCH;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    rf_port_if rf ();
    logic [search_pkg::RF_ADDR_W-1:0] rf_addr_q;

    assign rf.wr_en   = RF_WR_EN;
    assign rf.wr_addr = RF_WR_ADDR;
    assign rf.wr_data = RF_WR_DATA;
    assign rf.rd_addr = rf_addr_q;

    pattern_file #(
        .DEPTH (RF_DEPTH)
    ) u_pattern_file (
        .clk   (CLK),
        .rst_n (RST_N),
        .port  (rf.mem)
    );

    // ------------------------------------------------------------
    // Catch register
    // ------------------------------------------------------------
    logic       upper_sel_q;
    logic       anyplace_q;
    logic       preset_en_q;
    logic       mismatch_q;
    logic       byte_wait_q;
    logic [2:0] preset_val_q;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            upper_sel_q  <= 1'b0;
            preset_en_q  <= 1'b0;
            mismatch_q   <= 1'b0;
            byte_wait_q  <= 1'b0;
            preset_val_q <= search_pkg::CNT_RESET;
            rf_addr_q    <= search_pkg::RF_ADDR_RESET;
        end else if (search_strobe) begin
            upper_sel_q  <= DIRECTOR_WORD[search_pkg::BIT_UPPER_SEL];
            preset_en_q  <= DIRECTOR_WORD[search_pkg::BIT_PRESET_EN];
            mismatch_q   <= DIRECTOR_WORD[search_pkg::BIT_MISMATCH];
            byte_wait_q  <= DIRECTOR_WORD[search_pkg::BIT_BYTE_WAIT];
            preset_val_q <= DIRECTOR_WORD[search_pkg::PRESET_MSB:search_pkg::PRESET_LSB];
            rf_addr_q    <= DIRECTOR_WORD[search_pkg::RF_ADDR_MSB:search_pkg::RF_ADDR_LSB];
        end
    end

    // ------------------------------------------------------------
    // Shift clocks, captured bit and shift register
    // ------------------------------------------------------------
    logic       read_gate_q;
    logic       shift_clock_one;
    logic       shift_clock_two_q;
    logic       captured_read_bit_q;
    logic [7:0] shift_q;

    assign shift_clock_one = read_gate_q && rclk_sync_q[1] && !rclk_last_q;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            shift_clock_two_q   <= 1'b0;
            captured_read_bit_q <= 1'b0;
        end else begin
            shift_clock_two_q <= shift_clock_one;
            if (shift_clock_one) begin
                captured_read_bit_q <= rbit_sync_q[1];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            shift_q <= search_pkg::SHIFT_RESET;
        end else if (shift_clock_two_q) begin
            shift_q <= {shift_q[6:0], captured_read_bit_q};
        end
    end

    // ------------------------------------------------------------
    // Compare network
    // ------------------------------------------------------------
    logic [7:0] pattern;
    logic       pattern_match;

    assign pattern = upper_sel_q
                   ? rf.rd_data[search_pkg::UP_PAT_LSB +: search_pkg::PAT_W]
                   : rf.rd_data[search_pkg::LOW_PAT_LSB +: search_pkg::PAT_W];
    assign pattern_match = (shift_q == pattern) ^ mismatch_q;

    // ------------------------------------------------------------
    // Search sequencing
    // ------------------------------------------------------------
    logic       search_active_q;
    logic       sync_search_q;
    logic       sync_pending_q;
    logic       sync_time_q;
    logic       full_byte_q;
    logic       compare_time_q;
    logic       hold_q;
    logic       abort_q;
    logic       precond_q;
    logic [2:0] bit_count_q;
    logic       bit_count_three;
    logic       anyplace_done;
    logic       sync_eval;
    logic       search_done_pulse;
    logic       abort_set;

    assign bit_count_three = bit_count_q == search_pkg::CNT_THREE;
    assign anyplace_done   = shift_clock_one && anyplace_q && compare_time_q && pattern_match;
    assign sync_eval       = shift_clock_one && sync_pending_q && sync_time_q;
    assign search_done_pulse = anyplace_done || (sync_eval && pattern_match);
    assign abort_set = (sync_eval && !pattern_match) || (mark_pulse && search_active_q);

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            search_active_q <= 1'b0;
            sync_search_q   <= 1'b0;
        end else if (search_strobe) begin
            search_active_q <= 1'b1;
            sync_search_q   <= !DIRECTOR_WORD[search_pkg::BIT_ANYPLACE];
        end else if (other_strobe) begin
            search_active_q <= 1'b0;
            sync_search_q   <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            read_gate_q <= 1'b0;
        end else if (search_strobe && DIRECTOR_WORD[search_pkg::BIT_READ_GATE] && CONTROL_SELECT_EN) begin
            read_gate_q <= 1'b1;
        end else if (other_strobe) begin
            read_gate_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            anyplace_q <= 1'b0;
        end else if (search_strobe) begin
            anyplace_q <= DIRECTOR_WORD[search_pkg::BIT_ANYPLACE];
        end else if (anyplace_done || abort_set || other_strobe) begin
            anyplace_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            full_byte_q    <= 1'b0;
            compare_time_q <= 1'b0;
        end else if (search_strobe || anyplace_done || abort_set || other_strobe) begin
            full_byte_q    <= 1'b0;
            compare_time_q <= 1'b0;
        end else if (shift_clock_one && anyplace_q && bit_count_three && !compare_time_q) begin
            if (byte_wait_q && !full_byte_q) begin
                full_byte_q <= 1'b1;
            end else begin
                full_byte_q    <= 1'b0;
                compare_time_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sync_pending_q <= 1'b0;
            sync_time_q    <= 1'b0;
        end else if (search_strobe) begin
            sync_pending_q <= !DIRECTOR_WORD[search_pkg::BIT_ANYPLACE];
            sync_time_q    <= 1'b0;
        end else if (sync_eval || abort_set || other_strobe) begin
            sync_pending_q <= 1'b0;
            sync_time_q    <= 1'b0;
        end else if (shift_clock_one && sync_pending_q && bit_count_three) begin
            sync_time_q <= 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            bit_count_q <= search_pkg::CNT_RESET;
        end else if (anyplace_done) begin
            bit_count_q <= preset_en_q ? preset_val_q : search_pkg::CNT_RESET;
        end else if (shift_clock_one) begin
            bit_count_q <= bit_count_q + 3'h1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            hold_q <= 1'b0;
        end else if (search_strobe) begin
            hold_q <= 1'b1;
        end else if (search_done_pulse || abort_set) begin
            hold_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            abort_q <= 1'b0;
        end else if (abort_set) begin
            abort_q <= 1'b1;
        end else if (ABORT_CLEAR) begin
            abort_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            precond_q <= 1'b0;
        end else if (abort_set) begin
            precond_q <= 1'b0;
        end else if (search_strobe) begin
            precond_q <= 1'b1;
        end else if (other_strobe) begin
            precond_q <= 1'b0;
        end
    end

    // A registered done pulse keeps the sequencer edge clean at one cycle.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            DATA_DONE <= 1'b0;
        end else begin
            DATA_DONE <= search_done_pulse;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign READ_GATE         = read_gate_q;
    assign READ_IN_PROGRESS  = search_active_q;
    assign SECTOR_CHECK_EN   = search_active_q;
    assign READ_DATA_GATE    = search_active_q;
    assign CHECKWORD_READ_EN = search_active_q;
    assign CHECKWORD_PRECOND = precond_q;
    assign SEARCH_ACTIVE     = search_active_q;
    assign SYNC_SEARCH       = sync_search_q;
    assign EXECUTE_HOLD      = hold_q;
    assign SEARCH_ABORT      = abort_q;
    assign COMPOSITE_STATUS  = abort_q;
    assign FAULT             = abort_q;
    assign PATTERN_MATCH     = pattern_match;
    assign SHIFT_DATA        = shift_q;
    assign BIT_COUNT         = bit_count_q;

endmodule

// ==== read_sync_search_checker.sv ====
// Concurrent checks on the ports of the read pattern search block.
`timescale 1ns/1ps
module read_sync_search_checker #(
    parameter int RF_DEPTH = 16
) (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        DIRECTOR_EXECUTE_STROBE,
    input  wire logic        DIRECTOR_IS_SEARCH,
    input  wire logic [31:0] DIRECTOR_WORD,
    input  wire logic        CONTROL_SELECT_EN,
    input  wire logic        ABORT_CLEAR,
    input  wire logic        SECTOR_MARK,
    input  wire logic        READ_GATE,
    input  wire logic        READ_IN_PROGRESS,
    input  wire logic        SECTOR_CHECK_EN,
    input  wire logic        READ_DATA_GATE,
    input  wire logic        CHECKWORD_READ_EN,
    input  wire logic        CHECKWORD_PRECOND,
    input  wire logic        SEARCH_ACTIVE,
    input  wire logic        EXECUTE_HOLD,
    input  wire logic        DATA_DONE,
    input  wire logic        SEARCH_ABORT,
    input  wire logic        COMPOSITE_STATUS,
    input  wire logic        FAULT,
    input  wire logic [2:0]  BIT_COUNT
);
    logic       anyplace_q;
    logic [2:0] preset_q;
    logic       take;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    assign take = DIRECTOR_EXECUTE_STROBE && DIRECTOR_IS_SEARCH;

    // The preset is remembered so the count at completion can be judged.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            anyplace_q <= 1'b0;
            preset_q   <= 3'h0;
        end else if (take) begin
            anyplace_q <= DIRECTOR_WORD[21];
            preset_q   <= DIRECTOR_WORD[22] ? DIRECTOR_WORD[27:25] : 3'h0;
        end
    end

    gate_on_a: assert property (take && DIRECTOR_WORD[16] && CONTROL_SELECT_EN |=> READ_GATE)
        else $error("read gate not raised by first search");
    gate_refused_a: assert property (take && !CONTROL_SELECT_EN && !READ_GATE |=> !READ_GATE)
        else $error("read gate raised without control select");
    precond_armed_a: assert property (take && !SEARCH_ABORT |=> CHECKWORD_PRECOND && SEARCH_ACTIVE)
        else $error("search strobe did not arm the search");
    rip_follows_a: assert property (SEARCH_ACTIVE |-> READ_IN_PROGRESS && SECTOR_CHECK_EN
        && READ_DATA_GATE && CHECKWORD_READ_EN)
        else $error("read in progress enables missing");
    abort_status_a: assert property ((FAULT == SEARCH_ABORT) && (COMPOSITE_STATUS == SEARCH_ABORT))
        else $error("abort status outputs disagree");
    abort_sticky_a: assert property (SEARCH_ABORT && !ABORT_CLEAR |=> SEARCH_ABORT)
        else $error("abort flag dropped without clear");
    sector_abort_a: assert property ($rose(SECTOR_MARK) && SEARCH_ACTIVE |-> ##[1:6] SEARCH_ABORT)
        else $error("sector mark did not abort the search");
    hold_release_a: assert property ($fell(EXECUTE_HOLD) |->
        ##[0:1] (DATA_DONE || SEARCH_ABORT || $past(DATA_DONE)))
        else $error("execution released before data done");
    done_count_a: assert property (DATA_DONE && anyplace_q |-> BIT_COUNT == preset_q)
        else $error("bit counter not cleared or preset at done");

    cover property (DATA_DONE && anyplace_q);
    cover property ($rose(SEARCH_ABORT));
    cover property ($rose(READ_GATE));
endmodule

bind read_sync_search read_sync_search_checker #(.RF_DEPTH(RF_DEPTH)) chk (
    .CLK(CLK), .RST_N(RST_N), .DIRECTOR_EXECUTE_STROBE(DIRECTOR_EXECUTE_STROBE),
    .DIRECTOR_IS_SEARCH(DIRECTOR_IS_SEARCH), .DIRECTOR_WORD(DIRECTOR_WORD),
    .CONTROL_SELECT_EN(CONTROL_SELECT_EN), .ABORT_CLEAR(ABORT_CLEAR), .SECTOR_MARK(SECTOR_MARK),
    .READ_GATE(READ_GATE), .READ_IN_PROGRESS(READ_IN_PROGRESS), .SECTOR_CHECK_EN(SECTOR_CHECK_EN),
    .READ_DATA_GATE(READ_DATA_GATE), .CHECKWORD_READ_EN(CHECKWORD_READ_EN),
    .CHECKWORD_PRECOND(CHECKWORD_PRECOND), .SEARCH_ACTIVE(SEARCH_ACTIVE), .EXECUTE_HOLD(EXECUTE_HOLD),
    .DATA_DONE(DATA_DONE), .SEARCH_ABORT(SEARCH_ABORT), .COMPOSITE_STATUS(COMPOSITE_STATUS),
    .FAULT(FAULT), .BIT_COUNT(BIT_COUNT)
);

// ==== rf_port_if.sv ====
// Write and read port bundle of the pattern register file.
`timescale 1ns/1ps
interface rf_port_if;
    logic                               wr_en;
    logic [search_pkg::RF_ADDR_W-1:0]   wr_addr;
    logic [search_pkg::RF_DATA_W-1:0]   wr_data;
    logic [search_pkg::RF_ADDR_W-1:0]   rd_addr;
    logic [search_pkg::RF_DATA_W-1:0]   rd_data;

    modport owner (
        output wr_en,
        output wr_addr,
        output wr_data,
        output rd_addr,
        input  rd_data
    );

    modport mem (
        input  wr_en,
        input  wr_addr,
        input  wr_data,
        input  rd_addr,
        output rd_data
    );
endinterface

// ==== search_pkg.sv ====
// Constants shared by the disk read pattern search design.
package search_pkg;

    // ------------------------------------------------------------
    // Director word field positions
    // ------------------------------------------------------------
    localparam int DIR_W           = 32;
    localparam int BIT_UPPER_SEL   = 15;
    localparam int BIT_READ_GATE   = 16;
    localparam int BIT_ANYPLACE    = 21;
    localparam int BIT_PRESET_EN   = 22;
    localparam int BIT_MISMATCH    = 23;
    localparam int BIT_BYTE_WAIT   = 24;
    localparam int PRESET_LSB      = 25;
    localparam int PRESET_MSB      = 27;
    localparam int RF_ADDR_LSB     = 28;
    localparam int RF_ADDR_MSB     = 31;

    // ------------------------------------------------------------
    // Register file and pattern layout
    // ------------------------------------------------------------
    localparam int RF_ADDR_W       = 4;
    localparam int RF_DATA_W       = 16;
    localparam int PAT_W           = 8;
    localparam int LOW_PAT_LSB     = 0;
    localparam int UP_PAT_LSB      = 8;

    // ------------------------------------------------------------
    // Bit counter values and reset values
    // ------------------------------------------------------------
    localparam int CNT_W           = 3;
    localparam logic [2:0] CNT_THREE = 3'h3;
    localparam logic [2:0] CNT_RESET = 3'h0;
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    localparam logic [3:0] RF_ADDR_RESET = 4'h0;
    localparam int SYNC_STAGES     = 2;

    // ------------------------------------------------------------
    // Address pattern on the medium
    // ------------------------------------------------------------
    localparam int ZERO_RUN_BITS   = 300;
    localparam logic [7:0] SYNC_BYTE = 8'h33;

endpackage

// ==== testbench.sv ====
// Self-checking bench for the disk read pattern search block.
`timescale 1ns/1ps
module testbench;
    logic        clk, rst_n, strobe, is_search, rf_wr_en, cs_en, abort_clear, sector_mark;
    logic [31:0] word;
    logic [3:0]  rf_wr_addr, addr;
    logic [15:0] rf_wr_data, lfsr;
    logic [5:0]  sync_bits;
    logic        rd_clock, rd_bit, read_gate, active, read_in_progress, sync_search, done, abort, composite, fault;
    logic        pattern_match;
    logic [7:0]  shift_data;
    logic [2:0]  bit_count;
    int          failures;
    int          checks_done;

    read_sync_search uut (
        .CLK(clk), .RST_N(rst_n), .DIRECTOR_EXECUTE_STROBE(strobe), .DIRECTOR_IS_SEARCH(is_search),
        .DIRECTOR_WORD(word), .RF_WR_EN(rf_wr_en), .RF_WR_ADDR(rf_wr_addr), .RF_WR_DATA(rf_wr_data),
        .CONTROL_SELECT_EN(cs_en), .ABORT_CLEAR(abort_clear), .SECTOR_MARK(sector_mark),
        .DRIVE_READ_CLOCK(rd_clock), .DRIVE_READ_BIT(rd_bit), .READ_GATE(read_gate),
        .READ_IN_PROGRESS(read_in_progress), .SECTOR_CHECK_EN(), .READ_DATA_GATE(), .CHECKWORD_READ_EN(),
        .CHECKWORD_PRECOND(), .SEARCH_ACTIVE(active), .SYNC_SEARCH(sync_search), .EXECUTE_HOLD(),
        .DATA_DONE(done), .SEARCH_ABORT(abort), .COMPOSITE_STATUS(composite), .FAULT(fault),
        .PATTERN_MATCH(pattern_match), .SHIFT_DATA(shift_data), .BIT_COUNT(bit_count)
    );

    disk_drive_model drive (.read_gate(read_gate), .sync_bits(sync_bits), .read_clock(rd_clock), .read_bit(rd_bit));

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // The mismatch search ends one bit after the first sync bit, so four sync bits remain before count 4.
    function automatic logic [2:0] sync_preset();
        return 3'(search_pkg::CNT_THREE + 3'h1 - 3'h4);
    endfunction

    function automatic logic [5:0] bad_sync(input logic [5:0] r);
        logic [5:0] b;
        b = r | 6'h20;
        return (b == search_pkg::SYNC_BYTE[5:0]) ? b ^ 6'h04 : b;
    endfunction

    function automatic logic expect_abort();
        return sync_bits != search_pkg::SYNC_BYTE[5:0];
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %0h, seen %0h", name, exp, seen);
        end
    endtask

    task automatic issue(input logic search, input logic [31:0] w);
        @(negedge clk);
        strobe    = 1'b1;
        is_search = search;
        word      = w;
        @(negedge clk);
        strobe    = 1'b0;
    endtask

    task automatic write_rf(input logic [3:0] a, input logic [15:0] d);
        @(negedge clk);
        rf_wr_en   = 1'b1;
        rf_wr_addr = a;
        rf_wr_data = d;
        @(negedge clk);
        rf_wr_en   = 1'b0;
    endtask

    // A bounded wait: a lost completion ends as a counted mismatch, not a hang.
    task automatic wait_ev();
        int n;
        n = 0;
        while (done !== 1'b1 && abort !== 1'b1 && n < 8000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 8000) failures++;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #400_000;
        failures++;
        tally_and_finish();
    end

    initial begin
        {strobe, is_search, word, rf_wr_en, rf_wr_addr, rf_wr_data} = '0;
        {abort_clear, sector_mark, rst_n} = '0;
        cs_en     = 1'b1;
        sync_bits = search_pkg::SYNC_BYTE[5:0];
        lfsr      = 16'h38b8;
        failures  = 0;
        checks_done = 0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        addr  = lfsr[3:0];
        // load both patterns
        // The decoy word next door must never be compared against.
        write_rf(addr ^ 4'h1, 16'hffff);
        write_rf(addr, {search_pkg::SYNC_BYTE, 8'h00});
        // Test 0 finds the sync byte, test 1 meets a wrong one, test 2 sees a sector mark.
        for (int t = 0; t < 3; t++) begin
            lfsr = lfsr_next(lfsr);
            sync_bits = (t == 1) ? bad_sync(lfsr[5:0]) : search_pkg::SYNC_BYTE[5:0];
            issue(1'b1, {addr, lfsr[8:6], 25'h161_0000});
            check("READ_GATE", read_gate, 1'b1);
            check("READ_IN_PROGRESS", read_in_progress & active, 1'b1);
            if (t == 2) begin
                repeat (40) @(negedge clk);
                sector_mark = 1'b1;
                repeat (6) @(negedge clk);
                sector_mark = 1'b0;
                check("SEARCH_ABORT", abort, 1'b1);
                check("FAULT", fault & composite, 1'b1);
            end else begin
                wait_ev();
                check("DATA_DONE", done, 1'b1);
                check("SHIFT_DATA", shift_data, 8'h00);
                check("BIT_COUNT", bit_count, lfsr[8:6]);
                issue(1'b1, {addr, sync_preset(), 25'h0e0_0000});
                wait_ev();
                check("DATA_DONE", done, 1'b1);
                check("BIT_COUNT", bit_count, sync_preset());
                check("PATTERN_MATCH", pattern_match, 1'b1);
                issue(1'b1, {addr, 28'h000_8000});
                check("SYNC_SEARCH", sync_search, 1'b1);
                wait_ev();
                check("SEARCH_ABORT", abort, expect_abort());
                check("DATA_DONE", done, !expect_abort());
            end
            abort_clear = 1'b1;
            @(negedge clk);
            abort_clear = 1'b0;
            check("SEARCH_ABORT", abort, 1'b0);
            issue(1'b0, 32'h0000_0000);
            check("SEARCH_ACTIVE", active | sync_search | read_gate, 1'b0);
            $display("test %0d finished", t);
            repeat (20) @(negedge clk);
        end
        cs_en = 1'b0;
        issue(1'b1, {addr, 28'h121_0000});
        check("READ_GATE", read_gate, 1'b0);
        issue(1'b0, 32'h0000_0000);
        $display("test 3 finished");
        tally_and_finish();
    end
endmodule
